/* rtl/byte_store.sv */
// Storage leaves: a parameterised word FIFO and the byte array itself.
// Assumes one clock; the array has no reset so its contents survive resets.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Word FIFO with valid/ready on both sides
module word_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk,                    // System clock
    input wire logic rst_n,                  // Synchronous reset, active low
    input wire logic in_valid,               // Fill side offers a word
    output logic in_ready,                   // Room for a word
    input wire logic [WIDTH-1:0] in_data,    // Word to store
    output logic out_valid,                  // A word is waiting
    input wire logic out_ready,              // Drain side takes the word
    output logic [WIDTH-1:0] out_data        // Oldest word
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PW:0] FULL_COUNT = (PW+1)'(DEPTH);
    localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);

    logic [WIDTH-1:0] store [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0] count;
    logic push;
    logic pop;

    // Honest flags straight from the occupancy count
    assign in_ready = (count != FULL_COUNT);
    assign out_valid = (count != '0);
    assign out_data = store[rd_ptr];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // Storage is written only on an accepted word
    always_ff @(posedge clk) begin
        if (push) begin
            store[wr_ptr] <= in_data;
        end
    end

    // Pointers wrap explicitly so depths need not be powers of two
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == PTR_LAST) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == PTR_LAST) ? '0 : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule : word_fifo

////////////////////////////////////////////////////////////////////////////////
// Single-port byte array, registered read data
module byte_array #(
    parameter int AW = 14,
    parameter int DW = 8
) (
    input wire logic clk,                 // System clock
    input wire logic we,                  // Write this cycle, else read
    input wire logic [AW-1:0] addr,       // Location
    input wire logic [DW-1:0] wdata,      // Byte to store
    output logic [DW-1:0] rdata           // Byte read last non-write cycle
);
    logic [DW-1:0] cells [2**AW];

    // No reset: contents persist like the nonvolatile cells they stand for
    always_ff @(posedge clk) begin
        if (we) begin
            cells[addr] <= wdata;
        end else begin
            rdata <= cells[addr];
        end
    end
endmodule : byte_array

/* rtl/serial_byte_memory_pkg.sv */
// Shared constants and state codes for the two-wire byte memory target.
// Assumes a single 100 MHz system clock; all bus pins arrive asynchronously.
package serial_byte_memory_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Array geometry
    localparam int ARRAY_DEPTH = 16384;
    localparam int ADDR_W = 14;
    localparam int DATA_W = 8;
    localparam int FIFO_W = ADDR_W + DATA_W;
    localparam int FIFO_DEPTH_DEF = 16;
    localparam logic [ADDR_W-1:0] ADDR_LAST = 14'h3fff;
    localparam logic [ADDR_W-1:0] ADDR_FIRST = 14'h0000;

    ////////////////////////////////////////////////////////////////////////////
    // Target address byte layout
    localparam logic [3:0] DEV_TYPE = 4'ha;
    localparam int TYPE_MSB = 7;
    localparam int TYPE_LSB = 4;
    localparam int SEL_MSB = 3;
    localparam int SEL_LSB = 1;
    localparam int DIR_BIT = 0;
    // Reserved target address that answers with the identification bytes
    localparam logic [6:0] ID_ADDR = 7'h7c;
    // Identification bytes: maker, density, revision (value is arbitrary)
    localparam logic [23:0] DEVICE_ID_DEF = 24'h5a_21_03;
    localparam logic [1:0] ID_LAST = 2'h2;

    ////////////////////////////////////////////////////////////////////////////
    // Bit slots and pin reset levels
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam logic [3:0] BIT_FIRST = 4'h0;
    // Order: scl, sda, write guard, three select straps
    localparam logic [5:0] PIN_RESET = 6'h30;

    ////////////////////////////////////////////////////////////////////////////
    // Bus rates and the sampling margin they leave
    localparam longint CLK_HZ = 100_000_000;
    localparam longint SCL_STD_HZ = 100_000;
    localparam longint SCL_FAST_HZ = 400_000;
    localparam longint SCL_HS_HZ = 3_400_000;
    localparam int HS_HALF_CYCLES = int'(CLK_HZ / (2 * SCL_HS_HZ));

    ////////////////////////////////////////////////////////////////////////////
    // Transfer phases
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_DEVSEL  = 3'b001,
        ST_ADDR_HI = 3'b010,
        ST_ADDR_LO = 3'b011,
        ST_WRITE   = 3'b100,
        ST_READ    = 3'b101,
        ST_ID      = 3'b110
    } state_e;

endpackage : serial_byte_memory_pkg

/* rtl/serial_nonvolatile_byte_memory_port.sv */
// Two-wire serial target in front of a 16K x 8 byte array.
// Assumes scl and sda come straight from pins; the bus controller owns scl.
`timescale 1ns/1ps

// Notes on behaviour
// - 16384 bytes, one linear address space
// - Each acknowledged byte written unless write guard is high, no busy
// - Answer only when select bits match straps, or at the identification address
// - Unconnected straps read as zero; no pull-down here, only reset loads the strap synchroniser with zero
// - Sample on scl rise, drive on fall
// - Write guard high blocks all writes
// - Read-only identification bytes, never writable
// - Works at 100k, 400k, 3.4M clocks
// - Data line only pulled low or released
// - Address byte: type, select, direction
// - Two address bytes, top two bits ignored
// - Address advances per byte, wraps to zero
// - Ninth clock acknowledges; no-ack ends transfer
module serial_nonvolatile_byte_memory_port
    import serial_byte_memory_pkg::*;
#(
    parameter int FIFO_DEPTH = FIFO_DEPTH_DEF,
    parameter logic [23:0] DEVICE_ID = DEVICE_ID_DEF
) (
    input wire logic clk,                          // 100 MHz system clock
    input wire logic rst_n,                        // Synchronous reset, active low
    input wire logic scl,                          // Serial clock from controller
    input wire logic sda_in,                       // Data line level
    output logic sda_out,                          // Data line drive value
    output logic sda_oe,                           // High while pulling line low
    input wire logic [2:0] select_strap_inputs,    // Device select straps
    input wire logic write_guard                   // High blocks array writes
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and bus conditions
    logic [5:0] pins_meta;
    logic [5:0] pins_sync;
    logic scl_prev;
    logic sda_prev;
    logic scl_s;
    logic sda_s;
    logic guard_s;
    logic [2:0] straps_s;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pins_meta <= PIN_RESET;
            pins_sync <= PIN_RESET;
        end else begin
            pins_meta <= {scl, sda_in, write_guard, select_strap_inputs};
            pins_sync <= pins_meta;
        end
    end

    // Edge history taken from the second stage only
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
        end else begin
            scl_prev <= scl_s;
            sda_prev <= sda_s;
        end
    end

    assign scl_s = pins_sync[5];
    assign sda_s = pins_sync[4];
    assign guard_s = pins_sync[3];
    assign straps_s = pins_sync[2:0];
    // Even 3.4 MHz leaves ~14 samples per half period
    assign scl_rise = scl_s & ~scl_prev;
    assign scl_fall = ~scl_s & scl_prev;
    assign start_cond = scl_s & scl_prev & sda_prev & ~sda_s;
    assign stop_cond = scl_s & scl_prev & ~sda_prev & sda_s;

    ////////////////////////////////////////////////////////////////////////////
    // Byte decode
    state_e state;
    state_e pend_state;
    state_e load_state;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] tx_byte;
    logic [5:0] addr_hi;
    logic [ADDR_W-1:0] cur_addr;
    logic [1:0] id_idx;
    logic sda_low;
    logic acked;
    logic busy;
    logic sending;
    logic dev_match;
    logic id_match;
    logic accept;
    logic ack_fall;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [FIFO_W-1:0] fifo_out_data;
    logic mem_we;
    logic [ADDR_W-1:0] mem_addr;
    logic [DATA_W-1:0] mem_rdata;

    // Identification byte picked by index
    function automatic logic [7:0] id_byte(input logic [1:0] idx);
        case (idx)
            2'h0: id_byte = DEVICE_ID[23:16];
            2'h1: id_byte = DEVICE_ID[15:8];
            default: id_byte = DEVICE_ID[7:0];
        endcase
    endfunction : id_byte

    assign busy = (state != ST_IDLE) & ~start_cond & ~stop_cond;
    assign sending = (state == ST_READ) | (state == ST_ID);
    assign ack_fall = busy & scl_fall & (bit_cnt == ACK_SLOT);
    // Type nibble, select bits, direction bit
    // Select bits compared against the straps
    assign dev_match = (shift[TYPE_MSB:TYPE_LSB] == DEV_TYPE)
                     & (shift[SEL_MSB:SEL_LSB] == straps_s);
    assign id_match = (shift[7:1] == ID_ADDR) & shift[DIR_BIT];
    assign load_state = sending ? state : pend_state;

    // Acknowledge decision; a full FIFO refuses the byte
    always_comb begin
        accept = 1'b0;
        unique case (state)
            ST_DEVSEL: accept = dev_match | id_match;
            ST_ADDR_HI, ST_ADDR_LO: accept = 1'b1;
            ST_WRITE: accept = fifo_in_ready;
            ST_IDLE, ST_READ, ST_ID: accept = 1'b0;
            default: accept = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bit engine
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            pend_state <= ST_IDLE;
            bit_cnt <= BIT_FIRST;
            shift <= '0;
            tx_byte <= '0;
            addr_hi <= '0;
            id_idx <= '0;
            sda_low <= 1'b0;
            acked <= 1'b0;
        end else if (start_cond) begin
            // Start aborts anything in flight
            state <= ST_DEVSEL;
            bit_cnt <= BIT_FIRST;
            sda_low <= 1'b0;
        end else if (stop_cond) begin
            // Clear the slot count so a queued write is not stalled by the drain
            state <= ST_IDLE;
            bit_cnt <= BIT_FIRST;
            sda_low <= 1'b0;
        end else if (state != ST_IDLE) begin
            if (scl_rise) begin
                if (bit_cnt != ACK_SLOT) begin
                    // Shift in on the rising edge
                    shift <= {shift[6:0], sda_s};
                    bit_cnt <= bit_cnt + 1'b1;
                end else begin
                    bit_cnt <= BIT_FIRST;
                    // No-ack from either side ends transfer
                    if (sending ? sda_s : !acked) begin
                        state <= ST_IDLE;
                    end else begin
                        state <= load_state;
                        if (load_state == ST_ID) begin
                            tx_byte <= id_byte(id_idx);
                            id_idx <= (id_idx == ID_LAST) ? '0 : id_idx + 1'b1;
                        end else begin
                            tx_byte <= mem_rdata;
                        end
                    end
                end
            end else if (scl_fall) begin
                if (bit_cnt == ACK_SLOT) begin
                    // Pull low through the ninth clock
                    sda_low <= ~sending & accept;
                    acked <= accept;
                    if (state == ST_DEVSEL) begin
                        id_idx <= '0;
                        pend_state <= id_match ? ST_ID
                                    : (shift[DIR_BIT] ? ST_READ : ST_ADDR_HI);
                    end else if (state == ST_ADDR_HI) begin
                        addr_hi <= shift[5:0];
                        pend_state <= ST_ADDR_LO;
                    end else begin
                        pend_state <= ST_WRITE;
                    end
                end else begin
                    // Next bit changes on the falling edge
                    sda_low <= sending & ~tx_byte[3'd7 - bit_cnt[2:0]];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Address latch
    // Increment on the scl fall that opens the ack slot, wraps past the last location
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cur_addr <= ADDR_FIRST;
        end else if (ack_fall && state == ST_ADDR_LO) begin
            cur_addr <= {addr_hi, shift};
        end else if (ack_fall && (state == ST_READ || (state == ST_WRITE && fifo_in_ready))) begin
            // Guarded bytes still advance the address
            cur_addr <= (cur_addr == ADDR_LAST) ? ADDR_FIRST : cur_addr + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write path: FIFO then array
    // Guard high keeps the byte out of the FIFO
    // Pushed on the scl fall that opens the ack slot
    assign fifo_in_valid = ack_fall & (state == ST_WRITE) & ~guard_s;

    word_fifo #(
        .WIDTH(FIFO_W),
        .DEPTH(FIFO_DEPTH)
    ) write_queue (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data({cur_addr, shift}),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // Drain stalls over the ack slot so the read port holds the next byte
    assign fifo_out_ready = (bit_cnt != ACK_SLOT);
    assign mem_we = fifo_out_valid & fifo_out_ready;
    assign mem_addr = mem_we ? fifo_out_data[FIFO_W-1:DATA_W] : cur_addr;

    byte_array #(
        .AW(ADDR_W),
        .DW(DATA_W)
    ) cells (
        .clk(clk),
        .we(mem_we),
        .addr(mem_addr),
        .wdata(fifo_out_data[DATA_W-1:0]),
        .rdata(mem_rdata)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Open-drain output
    // Drive value fixed low; only the enable moves
    assign sda_out = 1'b0;
    assign sda_oe = sda_low;

endmodule : serial_nonvolatile_byte_memory_port

/* tb/bus_host_model.sv */
// Two-wire bus controller model: owns scl, pulls the data wire.
// Assumes the bench resolves the wire with a pull-up; 16 clk per bit.
`timescale 1ns/1ps
module bus_host_model (
    output logic scl,         // Serial clock, high while idle
    output logic sda_pull,    // High while pulling data low
    input wire logic sda,     // Resolved wire level
    input wire logic clk      // System clock
);
    logic [7:0] seen;  // Last byte or ack level seen
    event got;         // Fires when seen is fresh
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic tick(int n);
        repeat (n) @(posedge clk);
    endtask : tick
    // 160 ns bit period; pull low or release only
    task automatic bit_io(logic b, output logic r);
        sda_pull <= !b;
        tick(4);
        scl <= 1'b1;
        tick(4);
        r = sda;
        tick(4);
        scl <= 1'b0;
        tick(4);
    endtask : bit_io
    // Repeated start first lifts the wire while scl is low
    task automatic start();
        if (!scl) begin
            sda_pull <= 1'b0;
            tick(4);
            scl <= 1'b1;
            tick(4);
        end
        sda_pull <= 1'b1;
        tick(4);
        scl <= 1'b0;
        tick(4);
    endtask : start
    task automatic stop();
        sda_pull <= 1'b1;
        tick(4);
        scl <= 1'b1;
        tick(4);
        sda_pull <= 1'b0;
        tick(8);
    endtask : stop
    // ninth clock released for the ack
    task automatic send(logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(b[i], r);
        bit_io(1'b1, r);
        seen = {7'h00, r};
        -> got;
    endtask : send
    // last byte refused with a high ack
    task automatic recv(logic last);
        logic [7:0] v;
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            v[i] = r;
        end
        seen = v;
        -> got;
        bit_io(last, r);
    endtask : recv
endmodule : bus_host_model

/* tb/serial_byte_memory_asserts.sv */
// Pin-level checks on the two-wire byte memory target.
// Assumes bind to the top module; scl runs much slower than clk.
`timescale 1ns/1ps
module serial_byte_memory_asserts (
    input wire logic clk,                        // System clock
    input wire logic rst_n,                      // Sync reset, active low
    input wire logic scl,                        // Serial clock
    input wire logic sda_in,                     // Wire level
    input wire logic sda_out,                    // Drive value
    input wire logic sda_oe,                     // Pull enable
    input wire logic [2:0] select_strap_inputs,  // Select straps
    input wire logic write_guard                 // Write guard
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Cycles the current pull has lasted; saturates so it never wraps
    logic [8:0] oe_run;
    always_ff @(posedge clk) begin
        if (!rst_n || !sda_oe) begin
            oe_run <= 9'h000;
        end else if (oe_run != 9'h1ff) begin
            oe_run <= oe_run + 9'h001;
        end
    end

    ////////////////////////////////////////////////////////////
    property p_open_drain; sda_out == 1'b0; endproperty
    a_open_drain: assert property (p_open_drain) else $error("data line driven high");
    property p_release_quiet; $rose(rst_n) |-> !sda_oe [*4]; endproperty
    a_release_quiet: assert property (p_release_quiet) else $error("pull after reset");
    property p_pull_on_low; $rose(sda_oe) |-> !scl && !$past(scl, 2) && $past(scl, 7);
    endproperty
    a_pull_on_low: assert property (p_pull_on_low) else $error("pull not after fall");
    property p_release_on_low; $fell(sda_oe) |-> !scl && !$past(scl, 2) && $past(scl, 7);
    endproperty
    a_release_on_low: assert property (p_release_on_low) else $error("bad release");
    property p_stop_quiet; scl && $past(scl) && $rose(sda_in) |=> !sda_oe [*8]; endproperty
    a_stop_quiet: assert property (p_stop_quiet) else $error("pull after stop");
    property p_start_quiet; scl && $past(scl) && $fell(sda_in) |=> !sda_oe [*8]; endproperty
    a_start_quiet: assert property (p_start_quiet) else $error("pull after start");
    property p_pull_bounded; oe_run <= 9'h098; endproperty
    a_pull_bounded: assert property (p_pull_bounded) else $error("pull too long");
    property p_pull_min; $fell(sda_oe) |-> $past(oe_run) >= 9'h00c; endproperty
    a_pull_min: assert property (p_pull_min) else $error("pull too short");
    c_ack: cover property ($rose(sda_oe));
    c_long: cover property (oe_run == 9'h050);
    c_stop: cover property (scl && $rose(sda_in));
endmodule : serial_byte_memory_asserts

/* tb/tb.sv */
// Self-checking bench for the two-wire byte memory target.
// Assumes the host model drives all bus traffic; wire has a pull-up.
`timescale 1ns/1ps
module tb
    import serial_byte_memory_pkg::*;
;
    typedef struct {string name; logic [7:0] v;} note_s;
    logic clk;
    logic rst_n;
    logic write_guard;
    logic [2:0] straps;
    logic [2:0] s;
    logic scl;
    logic host_pull;
    logic sda_out;
    logic sda_oe;
    logic sda_wire;
    logic [7:0] d [3];
    logic [7:0] bad [3];
    note_s exp_q [$];
    int errors;
    int n_compared;
    int seed;
    // Wired-AND with the external pull-up
    assign sda_wire = !(host_pull || sda_oe);
    serial_nonvolatile_byte_memory_port u_serial_nonvolatile_byte_memory_port (.clk(clk),
        .rst_n(rst_n), .scl(scl), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
        .select_strap_inputs(straps), .write_guard(write_guard));
    bus_host_model u_bus_host_model (.scl(scl), .sda_pull(host_pull), .sda(sda_wire),
        .clk(clk));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(string name, logic [7:0] seen, logic [7:0] want);
        n_compared++;
        if (seen !== want) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, want, seen);
        end
    endtask : check
    task automatic put(logic [7:0] b, logic nak);
        exp_q.push_back('{"ack", {7'h00, nak}});
        u_bus_host_model.send(b);
    endtask : put
    task automatic get(logic [7:0] want, logic last);
        exp_q.push_back('{"rdata", want});
        u_bus_host_model.recv(last);
    endtask : get
    task automatic seek(logic [15:0] a);
        u_bus_host_model.start();
        put({DEV_TYPE, s, 1'b0}, 1'b0);
        put(a[15:8], 1'b0);
        put(a[7:0], 1'b0);
    endtask : seek
    task automatic rd_cur(logic [7:0] want);
        u_bus_host_model.start();
        put({DEV_TYPE, s, 1'b1}, 1'b0);
        get(want, 1'b1);
        u_bus_host_model.stop();
    endtask : rd_cur
    task automatic summarize();
        errors += exp_q.size();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize
    ////////////////////////////////////////////////////////////
    // Each result the host sees meets the oldest note
    initial begin
        note_s n;
        forever begin
            @(u_bus_host_model.got);
            n = exp_q.pop_front();
            check(n.name, u_bus_host_model.seen, n.v);
        end
    end
    // Guard against a hung bus
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        summarize();
    end
    initial begin
        seed = 44815;
        rst_n = 1'b0;
        write_guard = 1'b0;
        straps = 3'h0;
        repeat (20) @(posedge clk);
        s = 3'($random(seed));
        straps <= s;
        foreach (d[i]) d[i] = 8'($random(seed));
        bad = '{{DEV_TYPE, s ^ 3'h5, 1'b0}, {4'hb, s, 1'b1}, {ID_ADDR, 1'b0}};
        rst_n <= 1'b1;
        repeat (100) @(posedge clk);
        // Top address bits set, run across the last location
        seek(16'hfffe);
        foreach (d[i]) put(d[i], 1'b0);
        u_bus_host_model.stop();
        seek(16'h3ffe);
        u_bus_host_model.start();
        put({DEV_TYPE, s, 1'b1}, 1'b0);
        foreach (d[i]) get(d[i], i == 2);
        u_bus_host_model.stop();
        // Foreign select, foreign type, write to the identity
        foreach (bad[i]) begin
            u_bus_host_model.start();
            put(bad[i], 1'b1);
            u_bus_host_model.stop();
        end
        // Guarded byte acked, address still moves on
        write_guard <= 1'b1;
        seek(16'h3ffe);
        put(~d[0], 1'b0);
        u_bus_host_model.stop();
        write_guard <= 1'b0;
        rd_cur(d[1]);
        seek(16'h3ffe);
        u_bus_host_model.stop();
        rd_cur(d[0]);
        u_bus_host_model.start();
        put({ID_ADDR, 1'b1}, 1'b0);
        for (int i = 0; i < 4; i++) get(DEVICE_ID_DEF[8 * (2 - i % 3) +: 8], i == 3);
        u_bus_host_model.stop();
        // Second reset: latch back to zero, contents kept
        rst_n <= 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (100) @(posedge clk);
        rd_cur(d[2]);
        summarize();
    end
endmodule : tb
bind serial_nonvolatile_byte_memory_port serial_byte_memory_asserts u_serial_byte_memory_asserts (
    .clk(clk), .rst_n(rst_n), .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .select_strap_inputs(select_strap_inputs), .write_guard(write_guard));
